// ==== hw/rcm_ctrl.sv ====
// Purpose: Register file, lock control and rate readback for the recovery receiver
// Assumes: Pins ref_tick, data_tick and loss_of_lock are asynchronous to sys_clk_in
// Notes: Register reads answer one cycle after the request, from a flop
`timescale 1ns/1ns
`default_nettype none
module rcm_ctrl
    import rcm_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire rcm_reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_ack_out,
    input wire logic reference_clock_input_in,
    input wire logic data_tick_in,
    input wire logic loss_of_lock_flag_in,
    input wire logic [RCM_COARSE_WIDTH-1:0] rough_code_in,
    output rcm_mode_t mode_out,
    output logic [7:0] tertiary_config_out,
    output logic lock_ref_start_out,
    output logic acquire_start_out
);

    // Read data for one subaddress
    function automatic logic [7:0] read_mux(
        input logic [2:0] addr,
        input logic [RCM_FINE_WIDTH-1:0] fine,
        input logic [7:0] rough_hi,
        input logic [7:0] misc,
        input logic [7:0] pri,
        input logic [7:0] sec,
        input logic [7:0] ter
    );
        unique case (addr)
            RCM_ADDR_FINE_UPPER: read_mux = {1'b0, fine[22:16]};
            RCM_ADDR_FINE_MIDDLE: read_mux = fine[15:8];
            RCM_ADDR_FINE_LOWER: read_mux = fine[7:0];
            RCM_ADDR_ROUGH_UPPER: read_mux = rough_hi;
            RCM_ADDR_MISC_STATUS: read_mux = misc;
            RCM_ADDR_PRIMARY: read_mux = pri;
            RCM_ADDR_SECONDARY: read_mux = sec;
            RCM_ADDR_TERTIARY: read_mux = ter;
        endcase
    endfunction : read_mux

    // Falling edge of a written trigger bit
    function automatic logic fell(input logic old_bit, input logic new_bit);
        fell = old_bit & ~new_bit;
    endfunction : fell

    // Pin synchronisers
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] sync3_reg;
    logic ref_rise;
    logic data_rise;
    logic lol_rise;
    logic lol_now;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
        end else begin
            sync1_reg <= {loss_of_lock_flag_in, data_tick_in, reference_clock_input_in};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign ref_rise = sync2_reg[0] & ~sync3_reg[0];
    assign data_rise = sync2_reg[1] & ~sync3_reg[1];
    assign lol_now = sync2_reg[2];
    assign lol_rise = sync2_reg[2] & ~sync3_reg[2];

    // Configuration registers
    logic [7:0] pri_reg, pri_next;
    logic [7:0] sec_reg, sec_next;
    logic [7:0] ter_reg, ter_next;
    logic wr_pri;
    logic wr_sec;

    always_comb begin
        wr_pri = reg_req_in.wr && reg_req_in.addr == RCM_ADDR_PRIMARY;
        wr_sec = reg_req_in.wr && reg_req_in.addr == RCM_ADDR_SECONDARY;
        pri_next = pri_reg;
        sec_next = sec_reg;
        ter_next = ter_reg;
        if (wr_pri) begin
            pri_next = reg_req_in.wdata;
        end
        if (wr_sec) begin
            sec_next = reg_req_in.wdata;
        end
        if (reg_req_in.wr && reg_req_in.addr == RCM_ADDR_TERTIARY) begin
            ter_next = reg_req_in.wdata;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pri_reg <= RCM_PRIMARY_RESET;
            sec_reg <= RCM_SECONDARY_RESET;
            ter_reg <= RCM_TERTIARY_RESET;
        end else begin
            pri_reg <= pri_next;
            sec_reg <= sec_next;
            ter_reg <= ter_next;
        end
    end

    // Mode decode
    logic lock_ref_en;
    logic fine_en;
    logic [1:0] band;
    logic [3:0] ratio;
    logic meas_start;
    logic reacq_req;
    logic lock_ref_rise;

    always_comb begin
        lock_ref_en = pri_reg[RCM_PRI_LOCK_REF_BIT];
        // Unsupported combination: lock mode wins, measurement held off
        fine_en = pri_reg[RCM_PRI_FINE_EN_BIT] & ~lock_ref_en;
        band = pri_reg[RCM_PRI_BAND_LSB +: 2];
        ratio = pri_reg[RCM_PRI_RATIO_LSB +: 4];
        if (ratio > RCM_RATIO_MAX) begin
            ratio = RCM_RATIO_MAX;
        end
        lock_ref_rise = wr_pri && !pri_reg[RCM_PRI_LOCK_REF_BIT]
            && pri_next[RCM_PRI_LOCK_REF_BIT];
        meas_start = wr_sec && fell(sec_reg[RCM_SEC_MEAS_START_BIT],
            sec_next[RCM_SEC_MEAS_START_BIT]);
        reacq_req = wr_sec && fell(sec_reg[RCM_SEC_REACQ_BIT],
            sec_next[RCM_SEC_REACQ_BIT]);
    end

    // Fine measurement engine
    logic fine_done;
    logic [RCM_FINE_WIDTH-1:0] fine_count;

    rcm_rate_meter u_meter (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .enable_in(fine_en),
        .start_in(meas_start),
        .band_in(band),
        .ref_rise_in(ref_rise),
        .data_rise_in(data_rise),
        .done_out(fine_done),
        .count_out(fine_count)
    );

    // Coarse code capture and acquisition pulses
    logic [RCM_COARSE_WIDTH-1:0] coarse_reg, coarse_next;
    logic lock_start_reg, lock_start_next;
    logic acq_reg, acq_next;
    rcm_mode_t mode_reg, mode_next;

    always_comb begin
        coarse_next = coarse_reg;
        if (!lol_now) begin
            coarse_next = rough_code_in;
        end
        lock_start_next = lock_ref_rise;
        // Auto relock in lock mode; modes untouched by reacquire
        acq_next = reacq_req | (lock_ref_en & lol_rise);
        mode_next.lock_ref = lock_ref_en;
        mode_next.band = band;
        mode_next.ratio = ratio;
        mode_next.fine_en = fine_en;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            coarse_reg <= '0;
            lock_start_reg <= 1'b0;
            acq_reg <= 1'b0;
            mode_reg <= '0;
        end else begin
            coarse_reg <= coarse_next;
            lock_start_reg <= lock_start_next;
            acq_reg <= acq_next;
            mode_reg <= mode_next;
        end
    end

    // Register read port
    logic [7:0] misc_status;
    logic [7:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;

    always_comb begin
        misc_status = 8'h00;
        misc_status[RCM_MISC_COARSE_LSB_BIT] = coarse_reg[0];
        misc_status[RCM_MISC_DONE_BIT] = fine_done;
        rdata_next = rdata_reg;
        ack_next = reg_req_in.wr | reg_req_in.rd;
        if (reg_req_in.rd) begin
            rdata_next = read_mux(reg_req_in.addr, fine_count,
                coarse_reg[RCM_COARSE_WIDTH-1:1], misc_status, pri_reg, sec_reg, ter_reg);
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_reg <= 8'h00;
            ack_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign reg_ack_out = ack_reg;
    assign mode_out = mode_reg;
    assign tertiary_config_out = ter_reg;
    assign lock_ref_start_out = lock_start_reg;
    assign acquire_start_out = acq_reg;

endmodule : rcm_ctrl
`default_nettype wire

// ==== include/rcm_pkg.sv ====
// Purpose: Shared constants and types for the reference clock and rate measure control
// Assumes: Register accesses arrive already decoded from the two-wire serial slave
// Notes: Subaddresses follow the device register order of eight entries
//
// How it works
// - Lock-to-reference bit locks; never both enables
// - Band field picks reference range
// - Ratio field sets locked rate multiple
// - Lock loss in reference mode restarts acquisition
// - Lock enable rising edge starts new sequence
// - Fine mode measures data against reference
// - Default band lowest, field selects higher
// - Fine mode leaves lock acquisition untouched
// - Fine enable is a level
// - Start pulse clears complete, restarts count
// - Complete low while running, high when valid
// - Result split over three bytes
// - Count scales by two to fourteen plus band
// - Coarse nine-bit code from two registers
// - Reacquire pulse restarts acquisition, keeps modes
package rcm_pkg;

    localparam logic [2:0] RCM_ADDR_FINE_UPPER = 3'h0;
    localparam logic [2:0] RCM_ADDR_FINE_MIDDLE = 3'h1;
    localparam logic [2:0] RCM_ADDR_FINE_LOWER = 3'h2;
    localparam logic [2:0] RCM_ADDR_ROUGH_UPPER = 3'h3;
    localparam logic [2:0] RCM_ADDR_MISC_STATUS = 3'h4;
    localparam logic [2:0] RCM_ADDR_PRIMARY = 3'h5;
    localparam logic [2:0] RCM_ADDR_SECONDARY = 3'h6;
    localparam logic [2:0] RCM_ADDR_TERTIARY = 3'h7;

    localparam int RCM_PRI_LOCK_REF_BIT = 0;
    localparam int RCM_PRI_FINE_EN_BIT = 1;
    localparam int RCM_PRI_RATIO_LSB = 2;
    localparam int RCM_PRI_BAND_LSB = 6;
    localparam int RCM_SEC_MEAS_START_BIT = 3;
    localparam int RCM_SEC_REACQ_BIT = 5;
    localparam int RCM_MISC_COARSE_LSB_BIT = 0;
    localparam int RCM_MISC_DONE_BIT = 2;

    localparam logic [7:0] RCM_PRIMARY_RESET = 8'h00;
    localparam logic [7:0] RCM_SECONDARY_RESET = 8'h00;
    localparam logic [7:0] RCM_TERTIARY_RESET = 8'h00;
    localparam logic [3:0] RCM_RATIO_MAX = 4'h8;

    localparam int RCM_FINE_WIDTH = 23;
    localparam int RCM_WINDOW_BASE_EXP = 14;
    localparam int RCM_WINDOW_WIDTH = 18;
    localparam int RCM_COARSE_WIDTH = 9;

    // Typical measurement time at the lowest band, informative
    localparam int RCM_MEAS_TYP_MS = 80;
    localparam int RCM_SYS_CLK_HZ = 50000000;
    localparam int RCM_MEAS_TYP_CYCLES = RCM_MEAS_TYP_MS * (RCM_SYS_CLK_HZ / 1000);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } rcm_reg_req_t;

    typedef struct packed {
        logic lock_ref;
        logic [1:0] band;
        logic [3:0] ratio;
        logic fine_en;
    } rcm_mode_t;

endpackage : rcm_pkg

// ==== hw/rcm_rate_meter.sv ====
// Purpose: Fine data rate counter timed by reference clock edges
// Assumes: Edge pulses arrive already synchronised to sys_clk_in
// Notes: Window length is two to the fourteen plus band reference edges
`timescale 1ns/1ns
`default_nettype none
module rcm_rate_meter
    import rcm_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic start_in,
    input wire logic [1:0] band_in,
    input wire logic ref_rise_in,
    input wire logic data_rise_in,
    output logic done_out,
    output logic [RCM_FINE_WIDTH-1:0] count_out
);

    typedef enum logic [0:0] {
        RCM_MS_IDLE = 1'b0,
        RCM_MS_RUN = 1'b1
    } rcm_meter_state_t;

    function automatic logic [RCM_WINDOW_WIDTH-1:0] window_last(input logic [1:0] band);
        window_last = RCM_WINDOW_WIDTH'((32'h1 << (RCM_WINDOW_BASE_EXP + int'(band))) - 1);
    endfunction : window_last

    rcm_meter_state_t state_reg, state_next;
    logic [RCM_WINDOW_WIDTH-1:0] win_reg, win_next;
    logic [RCM_FINE_WIDTH-1:0] cnt_reg, cnt_next;
    logic [RCM_FINE_WIDTH-1:0] result_reg, result_next;
    logic done_reg, done_next;
    logic [RCM_FINE_WIDTH-1:0] cnt_inc;

    always_comb begin
        cnt_inc = (data_rise_in && cnt_reg != '1) ? cnt_reg + 1'b1 : cnt_reg;
        state_next = state_reg;
        win_next = win_reg;
        cnt_next = cnt_reg;
        result_next = result_reg;
        done_next = done_reg;
        if (!enable_in) begin
            state_next = RCM_MS_IDLE;
            done_next = 1'b0;
        end else if (start_in) begin
            state_next = RCM_MS_RUN;
            done_next = 1'b0;
            win_next = '0;
            cnt_next = '0;
        end else begin
            unique case (state_reg)
                RCM_MS_IDLE: begin
                end
                RCM_MS_RUN: begin
                    cnt_next = cnt_inc;
                    if (ref_rise_in) begin
                        win_next = win_reg + 1'b1;
                        if (win_reg == window_last(band_in)) begin
                            result_next = cnt_inc;
                            done_next = 1'b1;
                            state_next = RCM_MS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= RCM_MS_IDLE;
            win_reg <= '0;
            cnt_reg <= '0;
            result_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            win_reg <= win_next;
            cnt_reg <= cnt_next;
            result_reg <= result_next;
            done_reg <= done_next;
        end
    end

    assign done_out = done_reg;
    assign count_out = result_reg;

endmodule : rcm_rate_meter
`default_nettype wire

// ==== test/rcm_pin_source.sv ====
// Purpose: Reference and data pin source facing rcm_ctrl
// Assumes: Pins sampled on sys_clk_in
// Notes: Reference period four clocks, data period twice half_in
`timescale 1ns/1ns
`default_nettype none
module rcm_pin_source (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [3:0] half_in,
    output logic ref_out,
    output logic data_out
);
    logic [1:0] ref_cnt_reg;
    logic [3:0] data_cnt_reg;
    logic wrap;
    assign ref_out = ref_cnt_reg[1]; // Band 0 timebase
    assign wrap = (data_cnt_reg + 4'h1) >= half_in;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ref_cnt_reg <= 2'h0;
            data_cnt_reg <= 4'h0;
            data_out <= 1'b0;
        end else begin
            ref_cnt_reg <= ref_cnt_reg + 2'h1;
            data_cnt_reg <= wrap ? 4'h0 : data_cnt_reg + 4'h1;
            if (wrap) begin
                data_out <= ~data_out;
            end
        end
    end
endmodule : rcm_pin_source
`default_nettype wire

// ==== test/rcm_ctrl_properties.sv ====
// Purpose: Port checks for rcm_ctrl
// Assumes: Bench spaces register requests
// Notes: Keeps a shadow of secondary_config
`timescale 1ns/1ns
`default_nettype none
module rcm_ctrl_properties
    import rcm_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire rcm_reg_req_t reg_req_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic loss_of_lock_flag_in,
    input wire logic [RCM_COARSE_WIDTH-1:0] rough_code_in,
    input wire rcm_mode_t mode_out,
    input wire logic lock_ref_start_out,
    input wire logic acquire_start_out
);
    logic [7:0] sec_reg;
    logic [7:0] sec_next;
    logic pri_lock_reg;
    logic pri_lock_next;
    logic wr_pri;
    logic wr_sec;
    always_comb begin
        wr_pri = reg_req_in.wr && reg_req_in.addr == RCM_ADDR_PRIMARY;
        wr_sec = reg_req_in.wr && reg_req_in.addr == RCM_ADDR_SECONDARY;
        sec_next = wr_sec ? reg_req_in.wdata : sec_reg;
        pri_lock_next = wr_pri ? reg_req_in.wdata[0] : pri_lock_reg;
    end
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sec_reg <= 8'h00;
            pri_lock_reg <= 1'b0;
        end else begin
            sec_reg <= sec_next;
            pri_lock_reg <= pri_lock_next;
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    AST_LOCK_START: assert property (
        wr_pri && reg_req_in.wdata[0] && !pri_lock_reg |=> lock_ref_start_out)
        else $error("lock start pulse missing");
    AST_REACQ: assert property (
        wr_sec && !reg_req_in.wdata[5] && sec_reg[5] |=> acquire_start_out)
        else $error("reacquire pulse missing");
    AST_REACQ_ONE: assert property (
        acquire_start_out |=> !acquire_start_out) else $error("acquire pulse too long");
    AST_ZERO_QUIET: assert property (
        wr_sec && !sec_reg[5] && !pri_lock_reg |=> !acquire_start_out)
        else $error("acquire without falling trigger");
    AST_LOL_RELOCK: assert property (
        $rose(loss_of_lock_flag_in) && mode_out.lock_ref |-> ##[2:6] acquire_start_out)
        else $error("no relock after loss of lock");
    AST_BAND: assert property (
        wr_pri |-> ##2 mode_out.band == $past(reg_req_in.wdata[7:6], 2)
        && mode_out.ratio == (($past(reg_req_in.wdata[5:2], 2) > RCM_RATIO_MAX)
        ? RCM_RATIO_MAX : $past(reg_req_in.wdata[5:2], 2)))
        else $error("mode fields wrong");
    AST_UPPER_MSB: assert property (
        reg_req_in.rd && reg_req_in.addr == RCM_ADDR_FINE_UPPER |=> !reg_rdata_out[7])
        else $error("upper byte bit 7 set");
    AST_COARSE: assert property (
        reg_req_in.rd && reg_req_in.addr == RCM_ADDR_ROUGH_UPPER && !loss_of_lock_flag_in
        && !$past(loss_of_lock_flag_in, 4) && rough_code_in == $past(rough_code_in, 4)
        |=> reg_rdata_out == $past(rough_code_in[8:1])) else $error("coarse code wrong");
endmodule : rcm_ctrl_properties
bind rcm_ctrl rcm_ctrl_properties u_props (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out),
    .loss_of_lock_flag_in(loss_of_lock_flag_in),
    .rough_code_in(rough_code_in),
    .mode_out(mode_out),
    .lock_ref_start_out(lock_ref_start_out),
    .acquire_start_out(acquire_start_out)
);
`default_nettype wire

// ==== test/test_rcm_ctrl.sv ====
// Purpose: Self-checking bench for rcm_ctrl
// Assumes: Pin source drives reference and data pins
// Notes: One full fine measurement at band 0
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module test_rcm_ctrl
    import rcm_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    rcm_reg_req_t reg_req_in = '0;
    logic [7:0] reg_rdata_out;
    logic reg_ack_out;
    logic reference_clock_input_in;
    logic data_tick_in;
    logic loss_of_lock_flag_in = 1'b0;
    logic [8:0] rough_code_in = 9'h000;
    rcm_mode_t mode_out;
    logic [7:0] tertiary_config_out;
    logic lock_ref_start_out;
    logic acquire_start_out;
    logic [3:0] half = 4'h2;
    logic [7:0] rd;
    logic [7:0] d;
    logic [7:0] up;
    logic [7:0] mid;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int n_lock = 0;
    int n_acq = 0;
    int i;
    int diff;
    rcm_ctrl uut (.sys_clk_in, .rst_in, .reg_req_in, .reg_rdata_out, .reg_ack_out,
        .reference_clock_input_in, .data_tick_in, .loss_of_lock_flag_in, .rough_code_in,
        .mode_out, .tertiary_config_out, .lock_ref_start_out, .acquire_start_out);
    rcm_pin_source u_pins (.sys_clk_in, .rst_in, .half_in(half),
        .ref_out(reference_clock_input_in), .data_out(data_tick_in));
    always #10 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        n_lock += lock_ref_start_out;
        n_acq += acquire_start_out;
        cycles++;
        if (cycles == 90000) begin
            errors++;
            print_verdict();
        end
    end
    function automatic logic [3:0] exp_ratio(input logic [3:0] r);
        return (r > 4'h8) ? 4'h8 : r;
    endfunction : exp_ratio
    function automatic int exp_count(input int b, input int h);
        return (1 << (14 + b)) * 4 / (2 * h);
    endfunction : exp_count
    task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] wd);
        @(posedge sys_clk_in);
        reg_req_in <= '{w, !w, a, wd};
        @(posedge sys_clk_in);
        reg_req_in <= '0;
        @(negedge sys_clk_in);
        `CHECK("ack", 1'b1, reg_ack_out)
        rd = reg_rdata_out;
    endtask : xfer
    task automatic print_verdict;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    initial begin
        i = $urandom(32'hDDD3);
        half = 4'h2 + 4'($urandom_range(2));
        repeat (20) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        for (i = 5; i < 8; i++) begin
            xfer(1'b0, 3'(i), 8'h00);
            `CHECK("config reset", 8'h00, rd)
        end
        @(posedge sys_clk_in);
        rough_code_in <= 9'($urandom);
        xfer(1'b1, RCM_ADDR_ROUGH_UPPER, 8'hFF);
        repeat (4) @(posedge sys_clk_in);
        xfer(1'b0, RCM_ADDR_ROUGH_UPPER, 8'h00);
        `CHECK("rough upper", rough_code_in[8:1], rd)
        xfer(1'b0, RCM_ADDR_MISC_STATUS, 8'h00);
        `CHECK("rough lsb", rough_code_in[0], rd[0])
        for (i = 0; i < 6; i++) begin
            d = (i < 2) ? (i == 1 ? 8'hE0 : 8'h24) : (8'($urandom) & 8'hFC);
            xfer(1'b1, RCM_ADDR_PRIMARY, d);
            xfer(1'b0, RCM_ADDR_PRIMARY, 8'h00);
            `CHECK("primary", d, rd)
            `CHECK("band", d[7:6], mode_out.band)
            `CHECK("ratio", exp_ratio(d[5:2]), mode_out.ratio)
        end
        xfer(1'b1, RCM_ADDR_PRIMARY, 8'h01);
        xfer(1'b1, RCM_ADDR_PRIMARY, 8'h01);
        xfer(1'b1, RCM_ADDR_PRIMARY, 8'h00);
        xfer(1'b1, RCM_ADDR_PRIMARY, 8'h01);
        repeat (3) @(posedge sys_clk_in);
        `CHECK("lock starts", 2, n_lock)
        rd = 8'($urandom);
        loss_of_lock_flag_in <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        `CHECK("relock", 1, n_acq)
        rough_code_in <= ~rough_code_in;
        repeat (4) @(posedge sys_clk_in);
        xfer(1'b0, RCM_ADDR_ROUGH_UPPER, 8'h00);
        `CHECK("rough held", ~rough_code_in[8:1], rd)
        @(posedge sys_clk_in);
        loss_of_lock_flag_in <= 1'b0;
        xfer(1'b1, RCM_ADDR_SECONDARY, 8'h20);
        xfer(1'b1, RCM_ADDR_SECONDARY, 8'h00);
        xfer(1'b1, RCM_ADDR_SECONDARY, 8'h00);
        xfer(1'b0, RCM_ADDR_PRIMARY, 8'h00);
        `CHECK("acquires", 2, n_acq)
        `CHECK("mode kept", 8'h01, rd)
        xfer(1'b1, RCM_ADDR_PRIMARY, 8'h03);
        xfer(1'b1, RCM_ADDR_SECONDARY, 8'h08);
        xfer(1'b1, RCM_ADDR_SECONDARY, 8'h00);
        repeat (100) @(posedge sys_clk_in);
        xfer(1'b0, RCM_ADDR_MISC_STATUS, 8'h00);
        `CHECK("both enables", 3'b001, {rd[2], mode_out.fine_en, mode_out.lock_ref})
        xfer(1'b1, RCM_ADDR_PRIMARY, 8'h02);
        for (i = 0; i < 2; i++) begin
            xfer(1'b1, RCM_ADDR_SECONDARY, 8'h08);
            xfer(1'b1, RCM_ADDR_SECONDARY, 8'h00);
            xfer(1'b0, RCM_ADDR_MISC_STATUS, 8'h00);
            `CHECK("running", 1'b0, rd[2])
            repeat (200) @(posedge sys_clk_in);
        end
        i = 0;
        do begin
            repeat (64) @(posedge sys_clk_in);
            xfer(1'b0, RCM_ADDR_MISC_STATUS, 8'h00);
            i++;
        end while (rd[2] !== 1'b1 && i < 1100);
        `CHECK("done", 1'b1, rd[2])
        xfer(1'b0, RCM_ADDR_FINE_UPPER, 8'h00);
        up = rd;
        xfer(1'b0, RCM_ADDR_FINE_MIDDLE, 8'h00);
        mid = rd;
        xfer(1'b0, RCM_ADDR_FINE_LOWER, 8'h00);
        diff = int'({up[6:0], mid, rd}) - exp_count(0, int'(half));
        `CHECK("upper msb", 1'b0, up[7])
        `CHECK("count near", 1'b1, diff >= -2 && diff <= 2)
        `CHECK("lock untouched", 1'b0, mode_out.lock_ref)
        d = rd;
        xfer(1'b1, RCM_ADDR_SECONDARY, 8'h08);
        xfer(1'b1, RCM_ADDR_SECONDARY, 8'h00);
        xfer(1'b0, RCM_ADDR_MISC_STATUS, 8'h00);
        `CHECK("restart clears", 1'b0, rd[2])
        xfer(1'b0, RCM_ADDR_FINE_LOWER, 8'h00);
        `CHECK("result kept", d, rd)
        print_verdict();
    end
endmodule : test_rcm_ctrl
`default_nettype wire
